//--- rtl/pfp_pkg.sv
package pfp_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_PROT_CFG = 8'h00;
    localparam logic [7:0] ADDR_PROP_CFG = 8'h02;
    localparam logic [7:0] ADDR_INTLV = 8'h04;
    localparam logic [7:0] ADDR_DUTY_LIM = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_OFF_STYLE = 8'h0A;
    localparam logic [7:0] PROT_CFG_RST = 8'h43;
    localparam logic [7:0] PROP_CFG_RST = 8'h3F;
    localparam logic [7:0] PROP_CFG_MASK = 8'h3F;
    localparam logic [7:0] INTLV_RST = 8'h00;
    localparam logic [7:0] DUTY_LIM_RST = 8'hC0;
    localparam logic [7:0] OFF_STYLE_RST = 8'h00;
    // ****************************************
    // Field positions
    // ****************************************
    // Fault index doubles as bit position in config and status
    localparam int FB_OV = 1;
    localparam int FB_UV = 2;
    localparam int FB_OC = 3;
    localparam int FB_OT = 4;
    localparam int FB_TR = 5;
    localparam int FB_TW = 6;
    localparam int FB_PG = 0;
    localparam int TRACK_EN_BIT = 7;
    localparam int PHS_LSB = 6;
    localparam int STY_OT_CRIT = 0;
    localparam int STY_UV_CRIT = 1;
    localparam int STY_OV_EMERG = 2;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CORE_MHZ = 100;
    localparam int SYNC_KHZ = 500;
    localparam int SYNC_PER_CYC = CORE_MHZ * 1000 / SYNC_KHZ;
    localparam int LOCK_TOL_CYC = 8;
    localparam int RETRY_MS = 130;
    localparam int RETRY_TICKS = RETRY_MS * SYNC_KHZ;
    // Fault-line codes, MSB first, one bit per sync period, 1 = released
    localparam logic [3:0] OK_PAT_SEQ = 4'h0;
    localparam logic [3:0] OK_PAT_CRIT = 4'h4;
    localparam logic [3:0] OK_PAT_EMERG = 4'h5;

    typedef enum logic [1:0] {
        OFF_SEQ = 2'h0,
        OFF_CRIT = 2'h1,
        OFF_EMERG = 2'h2
    } pfp_off_t;

    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_RAMP = 6'h02,
        ST_RUN = 6'h04,
        ST_SEQ_OFF = 6'h08,
        ST_RETRY = 6'h10,
        ST_LATCHED = 6'h20
    } pfp_state_t;

    typedef struct packed {
        logic sync_clock_line;
        logic group_ok;
        logic vin_ok;
        logic turn_on;
        logic ramp_up_done;
        logic ramp_down_done;
        logic steady;
        logic above_prebias;
        logic overvoltage_error;
        logic undervoltage_fault;
        logic overcurrent_fault;
        logic overtemp_fault;
        logic tracking_fault;
        logic temp_warning;
        logic output_good;
    } pfp_pins_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pfp_reg_req_t;
endpackage

//--- rtl/pfp_pin_sync.sv
`timescale 1ns/10ps
module pfp_pin_sync (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire pfp_pkg::pfp_pins_t i_pins,
    output pfp_pkg::pfp_pins_t o_pins
);
    import pfp_pkg::*;

    typedef struct packed {
        pfp_pins_t meta;
        pfp_pins_t safe;
    } pfp_sync_st_t;

    pfp_sync_st_t s_r;
    pfp_sync_st_t s_nxt;

    always_comb begin
        s_nxt.meta = i_pins;
        s_nxt.safe = s_r.meta;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_pins = s_r.safe;
endmodule

//--- rtl/pfp_top.sv
// Notes on behaviour
// - Non-latching fault: retry start-up every 130 ms until cause clears.
// - Retry interval is fixed, but counted from ramp-down end after a sequenced turn-off.
// - Undervoltage may shut down sequenced, honouring delay and slew.
// - Non-propagating fault turns off only this device; line stays released.
// - Propagating fault pulls group line low; peers then turn off.
// - On a peer's code, perform the same turn-off type as signalled.
// - Line carries one of three codes, decoded from sync and line samples.
// - Group line changes only on a sync falling edge.
// - Overtemp while input OK, undervoltage in steady state; sequenced or critical.
// - Overcurrent, overvoltage after prebias; fast; OV may be emergency.
// - Tracking only in ramp-up, critical, can be disabled; warnings report.
// - Lock to the 500 kHz sync line; switching starts at falling edge.
// - Interleave delay measured from sync falling edge to PWM start.
// - Interleave lag is field value times 22.5 degrees.
// - Phase count codes 0..3 enable 1..4 phases; code 1 is 0 and 2.
// - Frequency select 0 is 500 kHz; reserved 1 is never applied.
// - Unused interleave register bit reads back zero.
// - Applied duty never exceeds the duty-limit register.
// - Latching fault stays off until cleared status or on/input cycled.
// - Emergency: high side off, low side on; critical: both off.
// - Per-fault propagate enable permits driving the group line.
`timescale 1ns/10ps
module pfp_top #(
    parameter int RETRY_TICKS_P = pfp_pkg::RETRY_TICKS
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire pfp_pkg::pfp_pins_t i_pins,
    input wire pfp_pkg::pfp_reg_req_t i_reg,
    input wire logic [7:0] i_duty_cmd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_ok_o,
    output logic o_ok_oe,
    output logic [3:0] o_pwm_hs,
    output logic [3:0] o_pwm_ls,
    output logic o_ramp_up_req,
    output logic o_ramp_down_req,
    output logic o_pll_locked
);
    import pfp_pkg::*;

    typedef struct packed {
        logic sd_d;
        logic [7:0] per_cnt;
        logic [7:0] period;
        logic locked;
        logic [7:0] prot_cfg;
        logic [7:0] prop_cfg;
        logic [7:0] intlv;
        logic [7:0] duty_lim;
        logic [7:0] status;
        logic [7:0] off_style;
        logic [7:0] rdata;
        logic rvalid;
        pfp_state_t st;
        pfp_off_t off_type;
        logic [2:0] cause;
        logic latch;
        logic to_off;
        logic [16:0] retry_cnt;
        logic tx_act;
        logic [3:0] tx_sh;
        logic ok_oe;
        logic rx_busy;
        logic [1:0] rx_cnt;
        logic [1:0] rx_hi;
        logic [3:0] hs;
        logic [3:0] ls;
    } pfp_st_t;

    pfp_st_t s_r;
    pfp_st_t s_nxt;
    pfp_pins_t p;

    pfp_pin_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_pins(i_pins),
        .o_pins(p)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] lag_pt(input logic [7:0] per,
                                          input logic [3:0] step);
        logic [11:0] prod;
        prod = per * step;
        return prod[11:4];
    endfunction
    function automatic logic [7:0] since(input logic [7:0] c,
                                         input logic [7:0] s,
                                         input logic [7:0] per);
        logic [7:0] d;
        d = (c >= s) ? 8'(c - s) : 8'(c + per - s);
        return d;
    endfunction
    logic sd_fall;
    logic sd_rise;
    logic [5:0] det;
    logic [5:0] raw;
    logic [2:0] fidx;
    pfp_off_t ftype;
    logic any_fault;
    logic [7:0] duty;
    logic [7:0] on_cnt;
    logic [15:0] on_prod;
    logic [3:0] ph_en;
    logic pwm_on;
    logic [1:0] rx_type;
    always_comb begin
        s_nxt = s_r;
        sd_fall = s_r.sd_d & ~p.sync_clock_line;
        sd_rise = ~s_r.sd_d & p.sync_clock_line;
        s_nxt.sd_d = p.sync_clock_line;
        pwm_on = 1'b0;
        rx_type = 2'h0;
        // ****************************************
        // Sync-line lock and PWM period counter
        // ****************************************
        if (sd_fall) begin
            s_nxt.per_cnt = 8'h00;
            s_nxt.period = 8'(s_r.per_cnt + 8'h01);
            s_nxt.locked =
                (32'(s_r.per_cnt) + 1 >= SYNC_PER_CYC - LOCK_TOL_CYC) &&
                (32'(s_r.per_cnt) + 1 <= SYNC_PER_CYC + LOCK_TOL_CYC);
        end else if (s_r.per_cnt != 8'hFF) begin
            s_nxt.per_cnt = 8'(s_r.per_cnt + 8'h01);
        end else begin
            s_nxt.locked = 1'b0;
        end

        // ****************************************
        // Fault qualification
        // ****************************************
        raw = '0;
        raw[FB_OV] = p.overvoltage_error;
        raw[FB_UV] = p.undervoltage_fault;
        raw[FB_OC] = p.overcurrent_fault;
        raw[FB_OT] = p.overtemp_fault;
        raw[FB_TR] = p.tracking_fault;
        det = '0;
        det[FB_OT] = raw[FB_OT] & p.vin_ok;
        det[FB_UV] = raw[FB_UV] & p.steady & (s_r.st == ST_RUN);
        det[FB_OV] = raw[FB_OV] & p.above_prebias;
        det[FB_OC] = raw[FB_OC] & p.above_prebias;
        det[FB_TR] = raw[FB_TR] & (s_r.st == ST_RAMP) &
            s_r.prot_cfg[TRACK_EN_BIT];

        // Fast faults first, then tracking, then overtemp, undervoltage last
        fidx = 3'(FB_UV);
        ftype = s_r.off_style[STY_UV_CRIT] ? OFF_CRIT : OFF_SEQ;
        if (det[FB_OV]) begin
            fidx = 3'(FB_OV);
            ftype = s_r.off_style[STY_OV_EMERG] ? OFF_EMERG : OFF_CRIT;
        end else if (det[FB_OC]) begin
            fidx = 3'(FB_OC);
            ftype = OFF_CRIT;
        end else if (det[FB_TR]) begin
            fidx = 3'(FB_TR);
            ftype = OFF_CRIT;
        end else if (det[FB_OT]) begin
            fidx = 3'(FB_OT);
            ftype = s_r.off_style[STY_OT_CRIT] ? OFF_CRIT : OFF_SEQ;
        end
        any_fault = |det[5:1];
        // ****************************************
        // Fault-line receiver, sampled at sync rising edges
        // ****************************************
        if (s_r.rx_busy) begin
            if (sd_rise) begin
                s_nxt.rx_hi = 2'(s_r.rx_hi + {1'b0, p.group_ok});
                s_nxt.rx_cnt = 2'(s_r.rx_cnt + 2'h1);
                if (s_r.rx_cnt == 2'h2) begin
                    s_nxt.rx_busy = 1'b0;
                end
            end
        end else if (sd_rise && !p.group_ok && !s_r.tx_act &&
                     (s_r.st == ST_RAMP || s_r.st == ST_RUN)) begin
            s_nxt.rx_busy = 1'b1;
            s_nxt.rx_cnt = 2'h0;
            s_nxt.rx_hi = 2'h0;
        end

        // ****************************************
        // Register port
        // ****************************************
        s_nxt.rvalid = i_reg.rd;
        if (i_reg.rd) begin
            case (i_reg.addr)
                ADDR_PROT_CFG: s_nxt.rdata = s_r.prot_cfg;
                ADDR_PROP_CFG: s_nxt.rdata = s_r.prop_cfg;
                ADDR_INTLV: s_nxt.rdata = s_r.intlv;
                ADDR_DUTY_LIM: s_nxt.rdata = s_r.duty_lim;
                ADDR_STATUS: s_nxt.rdata = s_r.status;
                ADDR_OFF_STYLE: s_nxt.rdata = s_r.off_style;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        if (i_reg.wr) begin
            case (i_reg.addr)
                ADDR_PROT_CFG: s_nxt.prot_cfg = i_reg.wdata;
                ADDR_PROP_CFG:
                    s_nxt.prop_cfg = i_reg.wdata & PROP_CFG_MASK;
                ADDR_INTLV: s_nxt.intlv = {i_reg.wdata[7:6], 2'b00,
                    i_reg.wdata[3:0]};
                ADDR_DUTY_LIM: s_nxt.duty_lim = i_reg.wdata;
                ADDR_STATUS: s_nxt.status = s_r.status & ~i_reg.wdata;
                ADDR_OFF_STYLE: s_nxt.off_style = i_reg.wdata;
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle clear
        s_nxt.status = s_nxt.status | {1'b0, p.temp_warning, det[5:1],
            p.steady & ~p.output_good};
        // ****************************************
        // Sequencer
        // ****************************************
        if (sd_fall && s_r.retry_cnt != 17'h1_FFFF) begin
            s_nxt.retry_cnt = 17'(s_r.retry_cnt + 17'h0_0001);
        end
        case (s_r.st)
            ST_OFF: begin
                s_nxt.tx_act = 1'b0;
                if (p.turn_on && p.vin_ok && s_r.locked && p.group_ok) begin
                    s_nxt.st = ST_RAMP;
                end
            end
            ST_RAMP, ST_RUN: begin
                if (s_r.st == ST_RAMP && p.ramp_up_done) begin
                    s_nxt.st = ST_RUN;
                end
                if (any_fault) begin
                    s_nxt.cause = fidx;
                    s_nxt.latch = s_r.prot_cfg[fidx];
                    s_nxt.off_type = ftype;
                    s_nxt.to_off = 1'b0;
                    s_nxt.retry_cnt = '0;
                    s_nxt.rx_busy = 1'b0;
                    // Disabled propagation keeps peers running
                    s_nxt.tx_act = s_r.prop_cfg[fidx];
                    case (ftype)
                        OFF_CRIT: s_nxt.tx_sh = OK_PAT_CRIT;
                        OFF_EMERG: s_nxt.tx_sh = OK_PAT_EMERG;
                        default: s_nxt.tx_sh = OK_PAT_SEQ;
                    endcase
                    s_nxt.st = (ftype == OFF_SEQ) ? ST_SEQ_OFF :
                        (s_r.prot_cfg[fidx] ? ST_LATCHED : ST_RETRY);
                end else if (s_r.rx_busy && !s_nxt.rx_busy) begin
                    rx_type = s_nxt.rx_hi;
                    s_nxt.cause = 3'h0;
                    s_nxt.latch = 1'b0;
                    s_nxt.to_off = 1'b0;
                    s_nxt.retry_cnt = '0;
                    s_nxt.off_type = (rx_type == 2'h0) ? OFF_SEQ :
                        (rx_type == 2'h1) ? OFF_CRIT : OFF_EMERG;
                    s_nxt.st = (rx_type == 2'h0) ? ST_SEQ_OFF : ST_RETRY;
                end else if (!p.turn_on) begin
                    s_nxt.off_type = OFF_SEQ;
                    s_nxt.to_off = 1'b1;
                    s_nxt.st = ST_SEQ_OFF;
                end
            end
            ST_SEQ_OFF: begin
                if (p.ramp_down_done) begin
                    s_nxt.retry_cnt = '0;
                    s_nxt.st = s_r.to_off ? ST_OFF :
                        (s_r.latch ? ST_LATCHED : ST_RETRY);
                end
            end
            ST_RETRY: begin
                // Interval counted from the fault, or from ramp_down_done after a sequenced turn-off
                if (sd_fall &&
                    s_r.retry_cnt >= 17'(RETRY_TICKS_P - 1)) begin
                    if ((p.group_ok || s_r.tx_act) && p.turn_on) begin
                        s_nxt.tx_act = 1'b0;
                        s_nxt.st = ST_RAMP;
                    end else begin
                        s_nxt.retry_cnt = '0;
                    end
                end
            end
            ST_LATCHED: begin
                if (!p.turn_on) begin
                    s_nxt.st = ST_OFF;
                end else if (s_r.retry_cnt >= 17'(RETRY_TICKS_P - 1) &&
                             !raw[s_r.cause] && !s_r.status[s_r.cause]) begin
                    s_nxt.st = ST_OFF;
                end
            end
            default: s_nxt.st = ST_OFF;
        endcase
        if (!p.vin_ok) begin
            s_nxt.st = ST_OFF;
        end
        // ****************************************
        // Open-drain fault line driver
        // ****************************************
        if (sd_fall) begin
            s_nxt.ok_oe = s_nxt.tx_act & ~s_nxt.tx_sh[3];
            if (s_nxt.tx_act) begin
                s_nxt.tx_sh = {s_nxt.tx_sh[2:0], 1'b0};
            end
        end

        // ****************************************
        // PWM with interleave and duty limit
        // ****************************************
        case (s_r.intlv[PHS_LSB+:2])
            2'h0: ph_en = 4'b0001;
            2'h1: ph_en = 4'b0101;
            2'h2: ph_en = 4'b0111;
            default: ph_en = 4'b1111;
        endcase
        duty = (i_duty_cmd > s_r.duty_lim) ? s_r.duty_lim :
            i_duty_cmd;
        on_prod = s_r.period * duty;
        on_cnt = on_prod[15:8];
        pwm_on = s_r.locked && (s_r.st == ST_RAMP || s_r.st == ST_RUN ||
            s_r.st == ST_SEQ_OFF);
        for (int k = 0; k < 4; k++) begin
            s_nxt.hs[k] = pwm_on && ph_en[k] &&
                since(s_nxt.per_cnt, lag_pt(s_r.period,
                4'(s_r.intlv[3:0] + 4'(4 * k))), s_r.period) <
                on_cnt;
            s_nxt.ls[k] = ph_en[k] && (pwm_on ? !s_nxt.hs[k] :
                (s_nxt.st != ST_OFF && s_r.off_type == OFF_EMERG));
        end
        if (!pwm_on) begin
            s_nxt.hs = 4'h0;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r <= '0;
            s_r.st <= ST_OFF;
            s_r.off_type <= OFF_SEQ;
            s_r.prot_cfg <= PROT_CFG_RST;
            s_r.prop_cfg <= PROP_CFG_RST;
            s_r.intlv <= INTLV_RST;
            s_r.duty_lim <= DUTY_LIM_RST;
            s_r.off_style <= OFF_STYLE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end
    always_comb begin
        o_reg_rdata = s_r.rdata;
        o_reg_rvalid = s_r.rvalid;
        o_ok_o = 1'b0;
        o_ok_oe = s_r.ok_oe;
        o_pwm_hs = s_r.hs;
        o_pwm_ls = s_r.ls;
        o_ramp_up_req = (s_r.st == ST_RAMP) || (s_r.st == ST_RUN);
        o_ramp_down_req = (s_r.st == ST_SEQ_OFF);
        o_pll_locked = s_r.locked;
    end
endmodule

//--- verification/pfp_top_sva.sv
`timescale 1ns/10ps
module pfp_top_sva (
    input logic i_core_clk,
    input logic i_arst_n,
    input pfp_pkg::pfp_pins_t i_pins,
    input pfp_pkg::pfp_reg_req_t i_reg,
    input logic [7:0] o_reg_rdata,
    input logic o_reg_rvalid,
    input logic o_ok_o,
    input logic o_ok_oe,
    input logic [3:0] o_pwm_hs,
    input logic [3:0] o_pwm_ls,
    input logic o_ramp_up_req,
    input logic o_ramp_down_req,
    input logic o_pll_locked
);
    import pfp_pkg::*;
    // ********
    // Shadows
    // ********
    logic sync_d_r;
    logic [9:0] fall_age_r;
    logic [9:0] edge_age_r;
    logic [1:0] phs_r;
    logic [4:0] prop_r;
    logic [3:0] mask;
    logic [4:0] faults;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_d_r <= 1'b0;
            fall_age_r <= 10'h3FF;
            edge_age_r <= 10'h000;
            phs_r <= 2'h0;
            prop_r <= PROP_CFG_RST[5:1];
        end else begin
            sync_d_r <= i_pins.sync_clock_line;
            fall_age_r <= (sync_d_r && !i_pins.sync_clock_line) ? 10'h000 :
                fall_age_r + {9'h000, fall_age_r != 10'h3FF};
            edge_age_r <= (sync_d_r != i_pins.sync_clock_line) ? 10'h000 :
                edge_age_r + {9'h000, edge_age_r != 10'h3FF};
            if (i_reg.wr && i_reg.addr == ADDR_INTLV)
                phs_r <= i_reg.wdata[7:6];
            if (i_reg.wr && i_reg.addr == ADDR_PROP_CFG)
                prop_r <= i_reg.wdata[5:1];
        end
    end
    assign mask = (phs_r == 2'h0) ? 4'h1 : (phs_r == 2'h1) ? 4'h5 :
        (phs_r == 2'h2) ? 4'h7 : 4'hF;
    assign faults = {i_pins.tracking_fault, i_pins.overtemp_fault,
        i_pins.overcurrent_fault, i_pins.undervoltage_fault,
        i_pins.overvoltage_error};
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);
    sequence intlv_rd;
        i_reg.rd && i_reg.addr == ADDR_INTLV;
    endsequence
    sequence oc_hit;
        (i_pins.overcurrent_fault && i_pins.above_prebias)[*3];
    endsequence
    sequence ot_hit;
        (i_pins.overtemp_fault && i_pins.vin_ok)[*3];
    endsequence
    // ********
    // Checks
    // ********
    od_data_low_a:
    assert property (o_ok_o == 1'b0)
        else $error("line data high");
    oe_on_fall_a:
    assert property ($changed(o_ok_oe) |-> fall_age_r <= 10'h008)
        else $error("line moved off sync fall");
    intlv_read_a:
    assert property (intlv_rd |=> o_reg_rvalid && o_reg_rdata[5:4] == 2'h0)
        else $error("interleave read bad");
    gate_overlap_a:
    assert property ((o_pwm_hs & o_pwm_ls) == 4'h0)
        else $error("both gates on");
    phase_mask_a:
    assert property ((o_pwm_hs & ~mask) == 4'h0)
        else $error("masked phase on");
    prop_gate_a:
    assert property ($rose(o_ok_oe) |-> (prop_r & faults) != 5'h00)
        else $error("pull without enabled fault");
    oc_fast_off_a:
    assert property (oc_hit |-> ##[0:5] (o_pwm_hs == 4'h0 && !o_ramp_up_req))
        else $error("slow overcurrent off");
    ot_turn_off_a:
    assert property (ot_hit |-> ##[0:5] !o_ramp_up_req)
        else $error("no overtemp off");
    lock_lost_a:
    assert property (edge_age_r > 10'h118 |-> !o_pll_locked)
        else $error("lock without sync");
endmodule

//--- verification/pfp_mgr_model.sv
`timescale 1ns/10ps
module pfp_mgr_model #(
    parameter time HALF_P = 1000ns
) (
    input logic i_run,
    input logic [3:0] i_peer_pat,
    input logic i_peer_send,
    input logic i_dut_oe,
    output logic o_sync,
    output logic o_group_ok
);
    logic peer_pull;
    int nbit;
    // Pull-up on the shared line; any party may pull it low
    assign o_group_ok = !(i_dut_oe || peer_pull);
    initial begin
        o_sync = 1'b1;
        peer_pull = 1'b0;
        nbit = 0;
        forever begin
            #(HALF_P);
            if (i_run)
                o_sync = ~o_sync;
            if (i_run && !o_sync) begin
                if (!i_peer_send) begin
                    nbit = 0;
                    peer_pull = 1'b0;
                end else begin
                    peer_pull = (nbit < 4) ? !i_peer_pat[3 - nbit] : 1'b1;
                    nbit++;
                end
            end
        end
    end
endmodule

//--- verification/pfp_top_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module pfp_top_tb_top;
    import pfp_pkg::*;
    logic clk, rst_n, run, send, oe, sync, gok, rv, up, dn, lock;
    logic [3:0] pat, hs, ls;
    logic [7:0] duty, rdata;
    pfp_pins_t p, pins;
    pfp_reg_req_t req;
    int n_errors, checked, cycles;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always_comb begin
        pins = p;
        pins.sync_clock_line = sync;
        pins.group_ok = gok;
    end
    pfp_mgr_model i_pfp_mgr_model (.i_run(run), .i_peer_pat(pat),
        .i_peer_send(send), .i_dut_oe(oe), .o_sync(sync), .o_group_ok(gok));
    pfp_top #(.RETRY_TICKS_P(8)) i_pfp_top (.i_core_clk(clk),
        .i_arst_n(rst_n), .i_pins(pins), .i_reg(req), .i_duty_cmd(duty),
        .o_reg_rdata(rdata), .o_reg_rvalid(rv), .o_ok_o(), .o_ok_oe(oe),
        .o_pwm_hs(hs), .o_pwm_ls(ls), .o_ramp_up_req(up),
        .o_ramp_down_req(dn), .o_pll_locked(lock));
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(1);
        req.wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        req.rd = 1'b1;
        req.addr = a;
        cyc(1);
        req.rd = 1'b0;
        `CHK(rv, 1'b1)
        `CHK(rdata, e)
        cyc(1);
    endtask
    task automatic restart(input logic [7:0] il, pr, st);
        int i;
        p = '0;
        {p.vin_ok, p.turn_on, p.ramp_up_done} = 3'h7;
        {p.steady, p.above_prebias, p.output_good} = 3'h7;
        rst_n = 1'b0;
        cyc(6);
        rst_n = 1'b1;
        reg_wr(ADDR_INTLV, il);
        reg_wr(ADDR_PROP_CFG, pr);
        reg_wr(ADDR_OFF_STYLE, st);
        for (i = 0; i < 3000 && !(lock && up); i++)
            cyc(1);
        `CHK(lock && up, 1'b1)
        cyc(400);
    endtask
    task automatic t_regs();
        reg_wr(ADDR_INTLV, 8'hFF);
        rd_chk(ADDR_INTLV, 8'hCF);
        rd_chk(8'h0C, 8'h00);
        reg_wr(ADDR_PROP_CFG, 8'hFF);
        rd_chk(ADDR_PROP_CFG, PROP_CFG_MASK);
    endtask
    task automatic t_pwm();
        int r, n, k, on;
        logic prev;
        logic [7:0] v[4] = '{8'h00, 8'h04, 8'h0F, 8'h40};
        logic [7:0] dc[4] = '{8'hFF, 8'h40, 8'hC0, 8'h80};
        int ph[4] = '{0, 0, 0, 2};
        int dl[4] = '{0, 50, 187, 100};
        int ot[4] = '{150, 50, 150, 100};
        for (r = 0; r < 4; r++) begin
            duty = dc[r];
            restart(v[r], PROP_CFG_RST, 8'h00);
            k = ph[r];
            @(negedge sync);
            n = 0;
            prev = hs[k];
            while (n < 400 && !(!prev && hs[k])) begin
                prev = hs[k];
                cyc(1);
                n++;
            end
            `CHK(n >= dl[r] && n <= dl[r] + 8, 1'b1)
            for (on = 0; on < 400 && hs[k]; on++)
                cyc(1);
            `CHK(on >= ot[r] - 3 && on <= ot[r] + 3, 1'b1)
        end
    endtask
    task automatic t_faults();
        int r, i;
        logic [3:0] got;
        int f[5] = '{2, 2, 4, 1, 3};
        logic [7:0] sty[5] = '{8'h00, 8'h02, 8'h00, 8'h04, 8'h00};
        logic [7:0] prp[5] = '{8'h3B, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
        logic [3:0] pt[5] = '{4'h0, 4'hB, 4'hF, 4'hA, 4'hB};
        logic [1:0] gt[5] = '{2'h3, 2'h0, 2'h3, 2'h1, 2'h0};
        for (r = 0; r < 5; r++) begin
            restart(8'h00, prp[r], sty[r]);
            @(negedge sync);
            cyc(1);
            case (f[r])
                1: p.overvoltage_error = 1'b1;
                2: p.undervoltage_fault = 1'b1;
                3: p.overcurrent_fault = 1'b1;
                default: p.overtemp_fault = 1'b1;
            endcase
            for (i = 3; i >= 0; i--) begin
                @(negedge sync);
                cyc(20);
                got[i] = oe;
            end
            `CHK(got, pt[r])
            if (gt[r] == 2'h3)
                `CHK(dn, 1'b1)
            else
                `CHK({hs[0], ls[0]}, gt[r])
        end
    endtask
    task automatic t_retry();
        int k, n;
        restart(8'h00, 8'h3B, 8'h00);
        p.ramp_down_done = 1'b1;
        p.undervoltage_fault = 1'b1;
        for (k = 0; k < 2; k++) begin
            for (n = 0; n < 300 && up; n++)
                cyc(1);
            for (n = 0; n < 3000 && !up; n++)
                cyc(1);
            `CHK(n >= 1400 && n <= 2100, 1'b1)
        end
        p.undervoltage_fault = 1'b0;
        cyc(4000);
        `CHK(up, 1'b1)
    endtask
    task automatic t_latch();
        int n;
        restart(8'h00, 8'h3B, 8'h00);
        reg_wr(ADDR_PROT_CFG, 8'h47);
        p.ramp_down_done = 1'b1;
        p.undervoltage_fault = 1'b1;
        cyc(500);
        p.undervoltage_fault = 1'b0;
        cyc(3000);
        `CHK(up, 1'b0)
        rd_chk(ADDR_STATUS, 8'h04);
        reg_wr(ADDR_STATUS, 8'h04);
        for (n = 0; n < 3000 && !up; n++)
            cyc(1);
        `CHK(up, 1'b1)
    endtask
    task automatic t_peer();
        int r;
        logic [3:0] cp[2] = '{4'h4, 4'h0};
        for (r = 0; r < 2; r++) begin
            restart(8'h00, PROP_CFG_RST, 8'h00);
            pat = cp[r];
            send = 1'b1;
            cyc(1200);
            `CHK({oe, dn}, {1'b0, r == 1})
            `CHK(r == 1 || {hs[0], ls[0]} == 2'h0, 1'b1)
            send = 1'b0;
        end
        run = 1'b0;
        cyc(400);
        `CHK(lock, 1'b0)
        run = 1'b1;
    endtask
    initial begin
        {rst_n, send, pat, p, req} = '0;
        run = 1'b1;
        duty = 8'hFF;
        n_errors = 0;
        checked = 0;
        cycles = 0;
        cyc(6);
        rst_n = 1'b1;
        rd_chk(ADDR_INTLV, INTLV_RST);
        rd_chk(ADDR_PROP_CFG, PROP_CFG_RST);
        t_regs();
        t_pwm();
        t_faults();
        t_retry();
        t_latch();
        t_peer();
        tally_and_finish();
    end
endmodule
bind pfp_top pfp_top_sva i_pfp_top_sva (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_pins(i_pins), .i_reg(i_reg),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_ok_o(o_ok_o), .o_ok_oe(o_ok_oe), .o_pwm_hs(o_pwm_hs),
    .o_pwm_ls(o_pwm_ls), .o_ramp_up_req(o_ramp_up_req),
    .o_ramp_down_req(o_ramp_down_req), .o_pll_locked(o_pll_locked));
